//--- inc/dtdu_consts.vh
// Purpose: Shared constants for the toggle/dither DAC update block.
// Assumes: Included by bare name from rtl files.
// Notes:   Definitions only.
`ifndef DTDU_CONSTS_VH
`define DTDU_CONSTS_VH

// Channel count, data width and toggle pin count
`define DTDU_NUM_CH 16
`define DTDU_DATA_W 16
`define DTDU_NUM_PINS 3
// Width of a per-channel pin selector; code 3 means no pin
`define DTDU_SEL_W 2
`define DTDU_SEL_NONE 2'h3
// Reset value of input and DAC registers (zero scale)
`define DTDU_RST_DATA 16'h0000
// Dither phase width and sine sample codes
`define DTDU_PH_W 2
`define DTDU_PH_MID0 2'h0
`define DTDU_PH_PEAK 2'h1
`define DTDU_PH_MID1 2'h2
`define DTDU_PH_TROUGH 2'h3

`endif

//--- rtl/dtdu_pin_sync.v
// Purpose: Bring one asynchronous toggle pin into sys_clk and flag its edges.
// Assumes: Pin may change at any time relative to sys_clk.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/10ps
`include "dtdu_consts.vh"

module dtdu_pin_sync (
  input wire sys_clk,
  input wire reset,
  input wire pinIn,
  output reg pinLevel_ff,
  output reg pinRise_ff,
  output reg pinFall_ff
);

  reg meta1_ff;
  reg meta2_ff;
  reg meta3_ff;
  wire nxt_pinLevel;

  // Hold the filtered level until stages two and three agree
  assign nxt_pinLevel = (meta2_ff == meta3_ff) ? meta3_ff : pinLevel_ff;

  always @(posedge sys_clk) begin
    if (reset) begin
      meta1_ff <= 1'h0;
      meta2_ff <= 1'h0;
      meta3_ff <= 1'h0;
      pinLevel_ff <= 1'h0;
      pinRise_ff <= 1'h0;
      pinFall_ff <= 1'h0;
    end else begin
      meta1_ff <= pinIn;
      meta2_ff <= meta1_ff;
      meta3_ff <= meta2_ff;
      pinLevel_ff <= nxt_pinLevel;
      pinRise_ff <= nxt_pinLevel & ~pinLevel_ff;
      pinFall_ff <= ~nxt_pinLevel & pinLevel_ff;
    end
  end

endmodule // dtdu_pin_sync

//--- rtl/dtdu_update.v
// Purpose: Per-channel DAC register update driven by toggle pin edges.
// Assumes: Input registers are written over a simple write strobe port;
//          mode, enable and pin selection are static configuration inputs.
// Notes:   Pin edges reach the DAC words four clocks after the pin is first sampled;
//          configuration inputs should only change while the pins are quiet.
// Operation
// RULE1: Toggle mode falling edge copies enabled channel input register A to DAC.
// RULE2: Toggle mode rising edge copies enabled channel input register B to DAC.
// RULE3: Dither mode uses pins as dither clocks, updating only on rising edges.
// RULE4: Only channels with toggle/dither enable set respond to pin edges.
// RULE5: Host holds unused toggle pins low and clears every enable bit.
// RULE6: Two stored input registers per channel; edges need no serial transfer.
`timescale 1ns/10ps
`include "dtdu_consts.vh"

module dtdu_update (
  input wire sys_clk,
  input wire reset,
  input wire [`DTDU_NUM_PINS-1:0] togglePins,
  input wire [`DTDU_NUM_CH-1:0] toggleDitherEnable,
  input wire [`DTDU_NUM_CH-1:0] ditherMode,
  input wire [`DTDU_NUM_CH*`DTDU_SEL_W-1:0] pinSelect,
  input wire inWrValid,
  input wire [3:0] inWrChan,
  input wire inWrRegB,
  input wire [`DTDU_DATA_W-1:0] inWrData,
  output reg [`DTDU_NUM_CH*`DTDU_DATA_W-1:0] dacWord_ff,
  output reg [`DTDU_NUM_CH-1:0] dacUpdated_ff,
  output reg [`DTDU_NUM_PINS-1:0] pinLevel_ff
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [`DTDU_DATA_W-1:0] inRegA_ff [0:`DTDU_NUM_CH-1];
  reg [`DTDU_DATA_W-1:0] inRegB_ff [0:`DTDU_NUM_CH-1];
  reg [`DTDU_PH_W-1:0] phase_ff [0:`DTDU_NUM_CH-1];

  wire [`DTDU_NUM_PINS-1:0] pinRise;
  wire [`DTDU_NUM_PINS-1:0] pinFall;
  wire [`DTDU_NUM_PINS-1:0] pinLevel;
  reg [`DTDU_NUM_CH-1:0] chanRise;
  reg [`DTDU_NUM_CH-1:0] chanFall;
  reg [`DTDU_SEL_W-1:0] chanSel;
  reg [`DTDU_NUM_CH-1:0] wrHitA;
  reg [`DTDU_NUM_CH-1:0] wrHitB;
  reg [`DTDU_NUM_CH*`DTDU_DATA_W-1:0] nxt_dacWord;
  reg [`DTDU_NUM_CH*`DTDU_PH_W-1:0] nxt_phase;
  integer c;
  integer k;
  integer m;
  integer n;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Pick the edge flag of the pin a channel listens to
  function pickPin;
    input [`DTDU_SEL_W-1:0] sel;
    input [`DTDU_NUM_PINS-1:0] flags;
    begin
      case (sel)
        2'h0: pickPin = flags[0];
        2'h1: pickPin = flags[1];
        2'h2: pickPin = flags[2];
        default: pickPin = 1'h0;
      endcase
    end
  endfunction

  // One-hot channel mask of a write, empty when no write is offered
  function [`DTDU_NUM_CH-1:0] chanMask;
    input valid;
    input [3:0] chan;
    integer j;
    begin
      chanMask = {`DTDU_NUM_CH{1'h0}};
      for (j = 0; j < `DTDU_NUM_CH; j = j + 1) begin
        if (valid && chan == j[3:0]) begin
          chanMask[j] = 1'h1;
        end
      end
    end
  endfunction

  // Four-point sine about A with amplitude B; sums wrap, so the host
  // must keep A +/- B inside the code range
  function [`DTDU_DATA_W-1:0] ditherCode;
    input [`DTDU_DATA_W-1:0] centre;
    input [`DTDU_DATA_W-1:0] amp;
    input [`DTDU_PH_W-1:0] ph;
    begin
      case (ph)
        `DTDU_PH_PEAK: ditherCode = centre + amp;
        `DTDU_PH_TROUGH: ditherCode = centre - amp;
        default: ditherCode = centre;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages per pin trade three clocks of latency for a clean edge;
  // a pulse shorter than about two clocks can be missed
  genvar g;
  generate
    for (g = 0; g < `DTDU_NUM_PINS; g = g + 1) begin : gPin
      dtdu_pin_sync uSync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(togglePins[g]),
        .pinLevel_ff(pinLevel[g]),
        .pinRise_ff(pinRise[g]),
        .pinFall_ff(pinFall[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Per-channel edge routing
  // ****************************************************************
  // A channel whose selector holds code 3 listens to no pin at all
  always @* begin
    chanRise = {`DTDU_NUM_CH{1'h0}};
    chanFall = {`DTDU_NUM_CH{1'h0}};
    chanSel = `DTDU_SEL_NONE;
    for (k = 0; k < `DTDU_NUM_CH; k = k + 1) begin
      chanSel = pinSelect[k*`DTDU_SEL_W +: `DTDU_SEL_W];
      chanRise[k] = toggleDitherEnable[k] &
                    pickPin(chanSel, pinRise); // [RULE4]
      // Dither channels never see falling edges
      chanFall[k] = toggleDitherEnable[k] & ~ditherMode[k] &
                    pickPin(chanSel, pinFall); // [RULE3] [RULE4]
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always @* begin
    wrHitA = chanMask(inWrValid & ~inWrRegB, inWrChan);
    wrHitB = chanMask(inWrValid & inWrRegB, inWrChan);
  end

  // ****************************************************************
  // Input registers
  // ****************************************************************
  // A write in the same cycle as an edge lands after the copy, so the
  // edge always transfers the value that was stored before it
  always @(posedge sys_clk) begin
    if (reset) begin
      for (c = 0; c < `DTDU_NUM_CH; c = c + 1) begin
        inRegA_ff[c] <= `DTDU_RST_DATA;
        inRegB_ff[c] <= `DTDU_RST_DATA;
      end
    end else begin
      for (c = 0; c < `DTDU_NUM_CH; c = c + 1) begin
        if (wrHitA[c]) begin
          inRegA_ff[c] <= inWrData; // [RULE6]
        end
        if (wrHitB[c]) begin
          inRegB_ff[c] <= inWrData; // [RULE6]
        end
      end
    end
  end

  // ****************************************************************
  // Next DAC words and dither phase
  // ****************************************************************
  // Only an edge routed to a channel moves its word
  always @* begin
    nxt_dacWord = dacWord_ff;
    nxt_phase = {`DTDU_NUM_CH*`DTDU_PH_W{1'h0}};
    for (m = 0; m < `DTDU_NUM_CH; m = m + 1) begin
      nxt_phase[m*`DTDU_PH_W +: `DTDU_PH_W] = phase_ff[m];
      if (ditherMode[m]) begin
        if (chanRise[m]) begin
          nxt_phase[m*`DTDU_PH_W +: `DTDU_PH_W] = phase_ff[m] + 2'h1; // [RULE3]
          nxt_dacWord[m*`DTDU_DATA_W +: `DTDU_DATA_W] =
            ditherCode(inRegA_ff[m], inRegB_ff[m], nxt_phase[m*`DTDU_PH_W +: `DTDU_PH_W]); // [RULE3]
        end
      end else begin
        // Phase restarts at MID0 so the first rise after a switch to dither gives the peak
        nxt_phase[m*`DTDU_PH_W +: `DTDU_PH_W] = `DTDU_PH_MID0;
        if (chanRise[m]) begin
          nxt_dacWord[m*`DTDU_DATA_W +: `DTDU_DATA_W] = inRegB_ff[m]; // [RULE2]
        end else if (chanFall[m]) begin
          nxt_dacWord[m*`DTDU_DATA_W +: `DTDU_DATA_W] = inRegA_ff[m]; // [RULE1]
        end
      end
    end
  end

  // ****************************************************************
  // DAC registers and dither phase
  // ****************************************************************
  // Registered so every output leaves straight from a flip-flop
  always @(posedge sys_clk) begin
    if (reset) begin
      dacWord_ff <= {`DTDU_NUM_CH{`DTDU_RST_DATA}};
      dacUpdated_ff <= {`DTDU_NUM_CH{1'h0}};
      pinLevel_ff <= {`DTDU_NUM_PINS{1'h0}};
      for (n = 0; n < `DTDU_NUM_CH; n = n + 1) begin
        phase_ff[n] <= `DTDU_PH_MID0;
      end
    end else begin
      pinLevel_ff <= pinLevel;
      dacUpdated_ff <= chanRise | chanFall;
      dacWord_ff <= nxt_dacWord;
      for (n = 0; n < `DTDU_NUM_CH; n = n + 1) begin
        phase_ff[n] <= nxt_phase[n*`DTDU_PH_W +: `DTDU_PH_W];
      end
    end
  end

endmodule // dtdu_update

//--- verif/dtdu_update_monitor.sv
// Purpose: Port-level checks of the toggle/dither update block.
// Assumes: Config inputs only change while the pins are quiet.
// Notes: Edge checks cover channel 0 on pin 0; enable and word-change checks cover every channel.
`timescale 1ns/10ps
`include "dtdu_consts.vh"
module dtdu_update_monitor (
  input wire sys_clk,
  input wire reset,
  input wire [15:0] toggleDitherEnable,
  input wire [15:0] ditherMode,
  input wire [31:0] pinSelect,
  input wire [255:0] dacWord_ff,
  input wire [15:0] dacUpdated_ff,
  input wire [2:0] pinLevel_ff
);
  // ****
  // Checks
  // ****
  wire cfg0 = toggleDitherEnable[0] && pinSelect[1:0] == 2'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence sRise0; !pinLevel_ff[0] ##1 pinLevel_ff[0]; endsequence
  sequence sFall0; pinLevel_ff[0] ##1 !pinLevel_ff[0]; endsequence
  AST_TOG_FALL: assert property (sFall0 ##0 (cfg0 && !ditherMode[0]) |-> dacUpdated_ff[0])
    else $error("toggle fall gave no update");
  AST_RISE: assert property (sRise0 ##0 cfg0 |-> dacUpdated_ff[0])
    else $error("rising edge gave no update");
  AST_DITH_FALL: assert property (sFall0 ##0 (cfg0 && ditherMode[0]) |-> !dacUpdated_ff[0])
    else $error("dither channel updated on a fall");
  AST_UPD_ON_EDGE: assert property ((dacUpdated_ff[0] && pinSelect[1:0] == 2'h0) |-> $changed(pinLevel_ff[0]))
    else $error("channel 0 updated without a pin edge");
  AST_ENABLE: assert property ((dacUpdated_ff & ~toggleDitherEnable) == 16'h0000)
    else $error("disabled channel updated");
  AST_NO_WRITE_UPD: assert property ($changed(dacWord_ff) |-> |dacUpdated_ff)
    else $error("dac word changed without an edge");
endmodule // dtdu_update_monitor
bind dtdu_update dtdu_update_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
  .toggleDitherEnable(toggleDitherEnable), .ditherMode(ditherMode), .pinSelect(pinSelect),
  .dacWord_ff(dacWord_ff), .dacUpdated_ff(dacUpdated_ff), .pinLevel_ff(pinLevel_ff));

//--- verif/dtdu_host_model.sv
// Purpose: Host logic that drives the three toggle pins.
// Assumes: Bench asks for levels held at least three cycles.
// Notes: Pins change on the clock edge, as host logic would.
`timescale 1ns/10ps
module dtdu_host_model (
  input wire sys_clk,
  input wire reset,
  input wire [2:0] pinCmd,
  output reg [2:0] togglePins
);
  // ****
  // Pin drive
  // ****
  always @(posedge sys_clk) begin
    togglePins <= reset ? 3'h0 : pinCmd;
  end
endmodule // dtdu_host_model

//--- verif/dtdu_update_tb_top.sv
// Purpose: Self-checking bench of the toggle/dither update block.
// Assumes: Edge to DAC latency under 8 cycles.
// Notes: Ch0 and ch1 share pin 0, ch2 uses pin 1, ch3 uses pin 2.
`timescale 1ns/10ps
`include "dtdu_consts.vh"
module dtdu_update_tb_top;
  // ****
  // Bench
  // ****
  reg sys_clk = 0, reset = 1, inWrValid = 0, inWrRegB = 0;
  reg [2:0] pinCmd = 3'h0;
  reg [15:0] ditherMode = 16'h0000, inWrData = 16'h0000, chanEnable = 16'h0001;
  reg [3:0] inWrChan = 4'h0;
  wire [2:0] togglePins, pinLevel;
  wire [255:0] dacWord;
  wire [15:0] dacUpd;
  integer fail_count = 0, cmp_count = 0, i, updCnt0 = 0, updCnt1 = 0;
  dtdu_host_model u_dtdu_host_model (.sys_clk(sys_clk), .reset(reset), .pinCmd(pinCmd),
    .togglePins(togglePins));
  dtdu_update u_dtdu_update (.sys_clk(sys_clk), .reset(reset), .togglePins(togglePins),
    .toggleDitherEnable(chanEnable), .ditherMode(ditherMode), .pinSelect(32'hffffff90),
    .inWrValid(inWrValid), .inWrChan(inWrChan), .inWrRegB(inWrRegB), .inWrData(inWrData),
    .dacWord_ff(dacWord), .dacUpdated_ff(dacUpd), .pinLevel_ff(pinLevel));
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input [15:0] got, input [15:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t dac word %h expected %h", $time, got, exp);
    end
  end endtask
  task wr(input [3:0] c, input b, input [15:0] d); begin
    @(negedge sys_clk);
    inWrValid = 1; inWrChan = c; inWrRegB = b; inWrData = d;
    @(negedge sys_clk);
    inWrValid = 0;
  end endtask
  task chk_lvl(input [2:0] got, input [2:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t pin levels %h expected %h", $time, got, exp);
    end
  end endtask
  task chk_cnt(input integer got, input integer exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t update count %0d expected %0d", $time, got, exp);
    end
  end endtask
  // Update pulses last one cycle, so they are counted at the falling edge
  always @(negedge sys_clk) begin
    if (dacUpd[0] === 1'h1) updCnt0 <= updCnt0 + 1;
    if (dacUpd[1] === 1'h1) updCnt1 <= updCnt1 + 1;
  end
  // Fixed wait covers sync plus update latency
  task pin(input [1:0] p, input v); begin
    @(negedge sys_clk);
    pinCmd[p] = v;
    repeat (8) @(negedge sys_clk);
  end endtask
  task t_toggle; begin
    pin(0, 1);
    chk(dacWord[15:0], 16'habcd);
    chk(dacWord[31:16], 16'h0000);
    chk_lvl(pinLevel, 3'h1);
    pin(0, 0);
    chk(dacWord[15:0], 16'h1234);
    wr(0, 1, 16'h5555);
    chk(dacWord[15:0], 16'h1234);
    pin(0, 1);
    chk(dacWord[15:0], 16'h5555);
    pin(0, 0);
  end endtask
  task t_dither; begin
    @(negedge sys_clk);
    ditherMode = 16'h0001;
    wr(0, 0, 16'h1000);
    wr(0, 1, 16'h0100);
    for (i = 0; i < 4; i = i + 1) begin
      pin(0, 1);
      chk(dacWord[15:0], i == 0 ? 16'h1100 : i == 2 ? 16'h0f00 : 16'h1000);
      pin(0, 0);
      chk(dacWord[15:0], i == 0 ? 16'h1100 : i == 2 ? 16'h0f00 : 16'h1000);
    end
    chk(dacWord[31:16], 16'h0000);
    chk_cnt(updCnt0, 8);
    chk_cnt(updCnt1, 0);
  end endtask
  task t_enable; begin
    @(negedge sys_clk);
    chanEnable = 16'h0003;
    pin(0, 1);
    chk(dacWord[31:16], 16'h7777);
    chk(dacWord[15:0], 16'h1100);
    pin(0, 0);
    chk(dacWord[31:16], 16'h0000);
    chk(dacWord[15:0], 16'h1100);
  end endtask
  task t_pins; begin
    wr(2, 1, 16'h2222);
    wr(3, 1, 16'h3333);
    @(negedge sys_clk);
    chanEnable = 16'h000c;
    pin(1, 1);
    chk(dacWord[47:32], 16'h2222);
    chk(dacWord[63:48], 16'h0000);
    chk_lvl(pinLevel, 3'h2);
    pin(2, 1);
    chk(dacWord[63:48], 16'h3333);
    pin(0, 1);
    chk(dacWord[15:0], 16'h1100);
    chk(dacWord[31:16], 16'h0000);
    chk_lvl(pinLevel, 3'h7);
    pin(1, 0);
    chk(dacWord[47:32], 16'h0000);
    pin(2, 0);
    pin(0, 0);
    chk_cnt(updCnt0, 9);
    chk_cnt(updCnt1, 2);
  end endtask
  task t_reset; begin
    @(negedge sys_clk);
    chanEnable = 16'h0001;
    ditherMode = 16'h0000;
    reset = 1;
    repeat (2) @(negedge sys_clk);
    reset = 0;
    chk(dacWord[15:0], 16'h0000);
    chk_lvl(pinLevel, 3'h0);
    wr(0, 1, 16'h4321);
    pin(0, 1);
    chk(dacWord[15:0], 16'h4321);
    pin(0, 0);
    chk(dacWord[15:0], 16'h0000);
  end endtask
  task end_of_test; begin
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    reset = 0;
    wr(0, 0, 16'h1234);
    wr(0, 1, 16'habcd);
    wr(1, 1, 16'h7777);
    t_toggle;
    t_dither;
    t_enable;
    t_pins;
    t_reset;
    end_of_test;
  end
endmodule // dtdu_update_tb_top
